// ---- bench/fsv_mem_model.sv ----
// far-side memory array answering the gate's requests
`timescale 1ns/1ns
module fsv_mem_model
  import fsv_pkg::*;
(
  input wire logic pclk,
  input wire fsv_pkg::fsv_mem_s mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] last_r = 8'h00;
  // idle bus inverts the last byte so stale data never matches
  assign mem_rdata = mem_req.rd ? (mem_req.addr[7:0] ^ 8'h5a) : ~last_r;
  always_ff @(posedge pclk) begin
    last_r <= mem_rdata;
  end
endmodule

// ---- bench/fsv_top_asserts.sv ----
// port checker for the flash security block
`timescale 1ns/1ns
module fsv_top_asserts
  import fsv_pkg::*;
#(
  parameter logic [15:0] RAM_LO = 16'h0080,
  parameter logic [15:0] RAM_HI = 16'h107f
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic background_mode_pin,
  input wire fsv_pkg::fsv_req_s cpu_req,
  input wire logic debug_enable_req,
  input wire fsv_pkg::fsv_mem_s mem_req,
  input wire logic [7:0] cpu_rdata,
  input wire logic debug_enable,
  input wire logic active_background,
  input wire logic secure
);
  logic ram_hit;
  logic bdc_ram;
  assign ram_hit = cpu_req.valid && cpu_req.addr >= RAM_LO && cpu_req.addr <= RAM_HI;
  assign bdc_ram = ram_hit && cpu_req.from_bdc;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // second secure sample skips the one-cycle lag after an unlock
  blk_write_a: assert property (
    (bdc_ram && cpu_req.write && secure) ##1 secure |-> !mem_req.wr)
    else $error("debug write reached secure ram");
  blk_read_a: assert property (
    (bdc_ram && !cpu_req.write && secure) ##1 secure |=> cpu_rdata == 8'h00)
    else $error("debug read of secure ram not zeroed");
  sec_access_a: assert property (
    ram_hit && cpu_req.write && cpu_req.exec_secure && !cpu_req.from_bdc
    |=> mem_req.wr && mem_req.addr == $past(cpu_req.addr))
    else $error("secure code write dropped");
  vec_reset_a: assert property (
    cpu_req.valid && cpu_req.vector_fetch && cpu_req.addr == 16'hfffe
    |=> mem_req.rd && mem_req.addr == 16'hfffe)
    else $error("reset vector moved");
  dbg_lock_a: assert property (debug_enable |-> !secure)
    else $error("debug enabled while secure");
  dbg_grant_a: assert property (!secure && debug_enable_req |=> debug_enable)
    else $error("debug enable not granted");
  boot_mode_a: assert property (
    $rose(presetn) |=> active_background == !$past(background_mode_pin))
    else $error("background mode not taken from pin");
  sec_load_a: assert property (
    $rose(presetn) |-> ##3 secure == (nonvolatile_option_byte[1:0] != FSV_SEC_OPEN))
    else $error("security not loaded from option byte");
  cover property (secure ##1 !secure);
  cover property (bdc_ram && secure);
  cover property (cpu_req.valid && cpu_req.vector_fetch);
endmodule
bind fsv_top fsv_top_asserts #(.RAM_LO(RAM_LO), .RAM_HI(RAM_HI)) chk_u (.pclk, .presetn,
  .nonvolatile_option_byte, .background_mode_pin, .cpu_req, .debug_enable_req, .mem_req,
  .cpu_rdata, .debug_enable, .active_background, .secure);

// ---- bench/tb.sv ----
// self-checking bench for the flash security and vector redirect block
`timescale 1ns/1ns
module tb;
  import fsv_pkg::*;
  localparam logic [63:0] KEY = 64'h8877665544332211;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic apb_from_debug = 1'b0;
  logic [7:0] nonvolatile_option_byte = 8'h83;
  logic background_mode_pin = 1'b0;
  fsv_req_s cpu_req = '0;
  logic [7:0] mem_rdata;
  logic blank_check_done = 1'b0;
  logic flash_all_erased = 1'b0;
  logic mass_erase_req = 1'b0;
  logic debug_enable_req = 1'b0;
  fsv_mem_s mem_req;
  logic [7:0] cpu_rdata;
  logic mass_erase_go;
  logic debug_enable;
  logic active_background;
  logic secure;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic err;
  logic [15:0] ma;
  logic [1:0] mk;
  logic [7:0] cd;

  always #25 pclk = ~pclk;

  fsv_mem_model mem_u (.pclk, .mem_req, .mem_rdata);

  fsv_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .apb_from_debug, .nonvolatile_option_byte, .nonvolatile_protection_byte(8'h00),
    .nonvolatile_aux_byte(8'h5c), .backdoor_key_bytes(KEY), .background_mode_pin, .cpu_req,
    .mem_rdata, .blank_check_done, .flash_all_erased, .mass_erase_req, .debug_enable_req,
    .mem_req, .cpu_rdata, .mass_erase_go, .debug_enable, .active_background, .secure);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic boot(input logic [7:0] o, input logic b);
    @(posedge pclk);
    presetn <= 1'b0;
    nonvolatile_option_byte <= o;
    background_mode_pin <= b;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // request held until the edge that samples pready, read data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // secure code runs from ram, so exec_secure and from_ram move together
  task automatic cpu(input logic w, vf, es, fb, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    cpu_req <= '{1'b1, w, vf, es, es, fb, a, d};
    @(posedge pclk);
    cpu_req <= '0;
    #1;
    ma = mem_req.addr;
    mk = {mem_req.wr, mem_req.key_wr};
    @(posedge pclk);
    #1;
    cd = cpu_rdata;
  endtask

  task automatic unlock(input logic [63:0] k);
    apb(1'b1, 8'h08, 32'h20);
    for (int i = 0; i < 8; i++) begin
      cpu(1'b1, 1'b0, 1'b1, 1'b0, 16'hffb0 + 16'(i), k[8*i +: 8]);
      chk(32'(mk), 32'h1);
    end
    apb(1'b1, 8'h08, 32'h0);
    repeat (2) @(posedge pclk);
    #1;
  endtask

  initial begin
    #(50 * 20000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    boot(8'h83, 1'b0);
    chk(32'(active_background), 32'h1);
    chk(32'(secure), 32'h1);
    @(posedge pclk);
    debug_enable_req <= 1'b1;
    mass_erase_req <= 1'b1;
    apb(1'b1, 8'h04, 32'hff);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h83);
    chk(32'(debug_enable), 32'h0);
    chk(32'(mass_erase_go), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0f);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h5c);
    apb(1'b0, 8'h24, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    cpu(1'b0, 1'b1, 1'b1, 1'b0, 16'hffe0, 8'h00);
    chk(32'(ma), 32'hfde0);
    chk(32'(cd), 32'hba);
    cpu(1'b0, 1'b1, 1'b1, 1'b0, 16'hffc0, 8'h00);
    chk(32'(ma), 32'hfdc0);
    cpu(1'b0, 1'b1, 1'b1, 1'b0, 16'hfffe, 8'h00);
    chk(32'(ma), 32'hfffe);
    cpu(1'b0, 1'b0, 1'b0, 1'b1, 16'h0100, 8'h00);
    chk(32'(cd), 32'h0);
    cpu(1'b1, 1'b0, 1'b0, 1'b1, 16'h0100, 8'h55);
    chk(32'(mk), 32'h0);
    cpu(1'b0, 1'b0, 1'b1, 1'b0, 16'h0100, 8'h00);
    chk(32'(cd), 32'h5a);
    cpu(1'b1, 1'b0, 1'b1, 1'b0, 16'h0100, 8'h55);
    chk(32'(mk), 32'h2);
    cpu(1'b1, 1'b0, 1'b1, 1'b0, 16'hffc0, 8'h55);
    chk(32'(mk), 32'h0);
    cpu(1'b1, 1'b0, 1'b1, 1'b0, 16'hffb0, 8'h55);
    chk(32'(mk), 32'h0);
    cpu(1'b1, 1'b0, 1'b1, 1'b0, 16'h2000, 8'h55);
    chk(32'(mk), 32'h2);
    apb(1'b1, 8'h0c, 32'h40);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h00);
    apb_from_debug <= 1'b1;
    apb(1'b1, 8'h0c, 32'h40);
    apb_from_debug <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h40);
    chk(32'(mass_erase_go), 32'h1);
    mass_erase_req <= 1'b0;
    apb(1'b1, 8'h08, 32'h20);
    cpu(1'b0, 1'b0, 1'b1, 1'b0, 16'h2000, 8'h00);
    chk(32'(cd), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h13);
    unlock(KEY ^ 64'h1);
    chk(32'(secure), 32'h1);
    unlock(KEY);
    chk(32'(secure), 32'h0);
    chk(32'(debug_enable), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h02);
    apb(1'b1, 8'h08, 32'h20);
    cpu(1'b1, 1'b0, 1'b0, 1'b0, 16'hffb0, KEY[7:0]);
    chk(32'(mk), 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    boot(8'h43, 1'b1);
    chk(32'(active_background), 32'h0);
    cpu(1'b0, 1'b1, 1'b1, 1'b0, 16'hffc0, 8'h00);
    chk(32'(ma), 32'hffc0);
    unlock(KEY);
    chk(32'(secure), 32'h1);
    @(posedge pclk);
    blank_check_done <= 1'b1;
    flash_all_erased <= 1'b1;
    @(posedge pclk);
    blank_check_done <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(secure), 32'h0);
    tally_and_finish();
  end
endmodule

// ---- core/fsv_key_cmp.sv ----
// backdoor key capture buffer and comparator
`timescale 1ns/1ns
module fsv_key_cmp #(
  parameter int KEY_BYTES = fsv_pkg::FSV_KEY_BYTES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic cap,
  input wire logic [2:0] cap_ofs,
  input wire logic [7:0] cap_data,
  input wire logic [8*KEY_BYTES-1:0] stored_key,
  output logic match
);
  import fsv_pkg::*;

  logic [7:0] buf_r [KEY_BYTES];
  logic [3:0] idx_r;
  logic err_r;
  logic [KEY_BYTES-1:0] byte_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= 4'h0;
      err_r <= 1'b0;
    end else if (restart) begin
      idx_r <= 4'h0;
      err_r <= 1'b0;
    end else if (cap) begin
      // out-of-order or excess bytes spoil the whole attempt
      if ({1'b0, cap_ofs} != idx_r || idx_r >= 4'(KEY_BYTES)) begin
        err_r <= 1'b1;
      end else begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < KEY_BYTES; i++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_r[i] <= 8'h00;
        end else if (cap && cap_ofs == 3'(i)) begin
          buf_r[i] <= cap_data;
        end
      end
      assign byte_ok[i] = buf_r[i] == stored_key[8*i +: 8];
    end
  endgenerate

  assign match = idx_r == 4'(KEY_BYTES) && !err_r && &byte_ok;
endmodule

// ---- core/fsv_pkg.sv ----
// constants, field layouts and carrier types of the flash security and vector redirect block
// How it works
// - any protection also guards reset and interrupt vectors
// - redirection needs vector_redirect_off programmed to zero
// - redirect only when flash partly, not wholly, protected
// - redirect vectors 0xffc0-0xfffd, never the reset vector
// - redirected vector read just below protected region
// - secure memory blocked: writes dropped, reads zero
// - secure code keeps access; registers, debug unsecured
// - reset copies option byte into working option register
// - only security bits 1:0 mean unsecured
// - secure blocks debug enable; background mode by pin
// - key enable zero disables the backdoor unlock
// - key access set turns key writes into captures
// - clearing key access with matching key unsecures
// - key writes accepted only from code in RAM
// - flash reads blocked while key access set
// - option, protection and key share vector block
// - protection register writable only by debug commands
// - blank flash found by blank check unsecures
// - nine high-page registers, three loaded at reset
// - reset loads protection; mass erase refused when protected
package fsv_pkg;

  localparam int FSV_HP_REGS = 9;
  localparam int FSV_KEY_BYTES = 8;

  // register offsets on the APB side, one word each
  localparam logic [7:0] FSV_OFS_DIVIDER = 8'h00;
  localparam logic [7:0] FSV_OFS_OPTION = 8'h04;
  localparam logic [7:0] FSV_OFS_CONFIG = 8'h08;
  localparam logic [7:0] FSV_OFS_PROTECT = 8'h0c;
  localparam logic [7:0] FSV_OFS_STATUS = 8'h10;
  localparam logic [7:0] FSV_OFS_AUX = 8'h20;
  localparam logic [7:0] FSV_OFS_LAST = 8'h20;

  // nonvolatile locations in the cpu address map
  localparam logic [15:0] FSV_NV_PROT_ADDR = 16'hffbd;
  localparam logic [15:0] FSV_NV_OPT_ADDR = 16'hffbf;
  localparam logic [15:0] FSV_KEY_BASE = 16'hffb0;
  localparam logic [15:0] FSV_VEC_LO = 16'hffc0;
  localparam logic [15:0] FSV_VEC_HI = 16'hfffd;
  localparam logic [15:0] FSV_NV_BLOCK_LO = 16'hfe00;

  // option register fields
  localparam int FSV_OPT_BACKDOOR_KEY_ENABLE_BIT = 7;
  localparam int FSV_OPT_NORED_BIT = 6;
  localparam logic [7:0] FSV_OPT_USED_MASK = 8'hc3;
  localparam logic [1:0] FSV_SEC_OPEN = 2'h2;
  localparam logic [1:0] FSV_SEC_RESET = 2'h3;

  // config register field
  localparam int FSV_CFG_KEY_COMPARE_ACCESS_BIT = 5;

  // protection register fields
  localparam int FSV_PROT_ALL_BIT = 7;
  localparam int FSV_PROT_DIS_BIT = 6;
  localparam int FSV_PROT_SIZE_LSB = 3;
  localparam logic [16:0] FSV_PROT_UNIT = 17'h00200;
  localparam logic [16:0] FSV_MAP_TOP = 17'h10000;
  localparam logic [7:0] FSV_PROT_RESET = 8'h40;

  localparam logic [7:0] FSV_OPT_RESET = 8'h03;
  localparam logic [7:0] FSV_HP_RESET = 8'h00;

  typedef struct packed {
    logic valid;
    logic write;
    logic vector_fetch;
    logic exec_secure;
    logic from_ram;
    logic from_bdc;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fsv_req_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic key_wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fsv_mem_s;

endpackage

// ---- core/fsv_top.sv ----
// flash security gate, vector redirect and high-page register file
`timescale 1ns/1ns
module fsv_top #(
  parameter logic [15:0] RAM_LO = 16'h0080,
  parameter logic [15:0] RAM_HI = 16'h107f,
  parameter logic [15:0] FLASH_LO = 16'h1080
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic apb_from_debug,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [7:0] nonvolatile_protection_byte,
  input wire logic [7:0] nonvolatile_aux_byte,
  input wire logic [63:0] backdoor_key_bytes,
  input wire logic background_mode_pin,
  input wire fsv_pkg::fsv_req_s cpu_req,
  input wire logic [7:0] mem_rdata,
  input wire logic blank_check_done,
  input wire logic flash_all_erased,
  input wire logic mass_erase_req,
  input wire logic debug_enable_req,
  output fsv_pkg::fsv_mem_s mem_req,
  output logic [7:0] cpu_rdata,
  output logic mass_erase_go,
  output logic debug_enable,
  output logic active_background,
  output logic secure
);
  import fsv_pkg::*;

  // high-page register file
  logic [7:0] hp_r [FSV_HP_REGS];
  logic [1:0] sec_r;
  logic load_pending_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  fsv_mem_s mem_r;
  logic zero_rd_r;
  logic [7:0] cpu_rdata_r;
  logic mass_erase_r;
  logic debug_en_r;
  logic bgnd_r;
  logic secure_r;

  logic [3:0] reg_idx;
  logic reg_hit;
  logic apb_setup;
  logic apb_wr;
  logic [7:0] opt;
  logic [7:0] prot;
  logic key_acc;
  logic key_en;
  logic is_secure;
  logic prot_all;
  logic prot_block;
  logic any_prot;
  logic [16:0] prot_size;
  logic [16:0] prot_start;
  logic redirect_on;
  logic in_ram;
  logic in_flash;
  logic in_vec;
  logic in_key;
  logic blocked;
  logic wr_prot_hit;
  logic key_cap;
  logic key_acc_clear;
  logic key_match;
  fsv_mem_s mem_nxt;
  logic zero_rd_nxt;
  logic [31:0] rd_word;

  assign opt = hp_r[FSV_OFS_OPTION[5:2]];
  assign prot = hp_r[FSV_OFS_PROTECT[5:2]];
  assign key_acc = hp_r[FSV_OFS_CONFIG[5:2]][FSV_CFG_KEY_COMPARE_ACCESS_BIT];
  assign key_en = opt[FSV_OPT_BACKDOOR_KEY_ENABLE_BIT];
  assign is_secure = sec_r != FSV_SEC_OPEN;

  // apb decode
  assign reg_idx = paddr[5:2];
  assign reg_hit = paddr[1:0] == 2'h0 && paddr <= FSV_OFS_LAST;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready_r && pwrite && reg_hit;
  assign key_acc_clear = apb_wr && reg_idx == FSV_OFS_CONFIG[5:2] && key_acc && !pwdata[FSV_CFG_KEY_COMPARE_ACCESS_BIT];

  // protection geometry: block of 512 bytes shifted by the size code
  assign prot_all = prot[FSV_PROT_ALL_BIT];
  assign prot_block = !prot[FSV_PROT_DIS_BIT];
  assign any_prot = prot_all || prot_block;
  assign prot_size = FSV_PROT_UNIT << prot[FSV_PROT_SIZE_LSB +: 3];
  assign prot_start = FSV_MAP_TOP - prot_size;
  // software must keep the region at or below 32K when redirecting
  assign redirect_on = !opt[FSV_OPT_NORED_BIT] && prot_block && !prot_all;

  // cpu address classes
  assign in_ram = cpu_req.addr >= RAM_LO && cpu_req.addr <= RAM_HI;
  assign in_flash = cpu_req.addr >= FLASH_LO;
  assign in_vec = cpu_req.addr >= FSV_VEC_LO && cpu_req.addr <= FSV_VEC_HI;
  assign in_key = cpu_req.addr[15:3] == FSV_KEY_BASE[15:3];

  // only flash and ram are secure resources; everything else stays open
  assign blocked = is_secure && (in_ram || in_flash) && (cpu_req.from_bdc || !cpu_req.exec_secure);

  // the nv block covers vectors, options and key, so one protect covers all
  assign wr_prot_hit = in_flash && (prot_all || (prot_block && {1'b0, cpu_req.addr} >= prot_start)
                       || (any_prot && cpu_req.addr >= FSV_NV_BLOCK_LO));

  // key bytes go to the comparator, never into a flash command
  assign key_cap = cpu_req.valid && cpu_req.write && key_acc && in_key && cpu_req.from_ram
                   && !cpu_req.from_bdc && !blocked;

  always_comb begin
    mem_nxt = '0;
    zero_rd_nxt = 1'b0;
    mem_nxt.addr = cpu_req.addr;
    mem_nxt.wdata = cpu_req.wdata;
    if (cpu_req.valid && !load_pending_r) begin
      if (cpu_req.write) begin
        mem_nxt.key_wr = key_cap;
        mem_nxt.wr = !key_cap && !blocked && !wr_prot_hit && !(key_acc && in_key);
      end else begin
        mem_nxt.rd = 1'b1;
        zero_rd_nxt = blocked || (key_acc && in_flash);
        if (redirect_on && cpu_req.vector_fetch && in_vec) begin
          mem_nxt.addr = cpu_req.addr - prot_size[15:0];
        end
      end
    end else if (cpu_req.valid) begin
      zero_rd_nxt = !cpu_req.write;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_r <= '0;
      zero_rd_r <= 1'b0;
      cpu_rdata_r <= 8'h00;
    end else begin
      mem_r <= mem_nxt;
      zero_rd_r <= zero_rd_nxt;
      // memory answers during the cycle the request stands on mem_req
      cpu_rdata_r <= zero_rd_r ? 8'h00 : mem_rdata;
    end
  end

  // async reset can only take constants, so nv bytes load on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pending_r <= 1'b1;
    end else begin
      load_pending_r <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < FSV_HP_REGS; g++) begin : g_hp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          if (g == int'(FSV_OFS_OPTION[5:2])) begin
            hp_r[g] <= FSV_OPT_RESET;
          end else if (g == int'(FSV_OFS_PROTECT[5:2])) begin
            hp_r[g] <= FSV_PROT_RESET;
          end else begin
            hp_r[g] <= FSV_HP_RESET;
          end
        end else if (load_pending_r) begin
          if (g == int'(FSV_OFS_OPTION[5:2])) begin
            hp_r[g] <= nonvolatile_option_byte & FSV_OPT_USED_MASK;
          end else if (g == int'(FSV_OFS_PROTECT[5:2])) begin
            hp_r[g] <= nonvolatile_protection_byte;
          end else if (g == int'(FSV_OFS_AUX[5:2])) begin
            hp_r[g] <= nonvolatile_aux_byte;
          end
        end else if (apb_wr && reg_idx == 4'(g)) begin
          if (g == int'(FSV_OFS_PROTECT[5:2])) begin
            if (apb_from_debug) begin
              hp_r[g] <= pwdata[7:0];
            end
          end else if (g == int'(FSV_OFS_CONFIG[5:2])) begin
            hp_r[g] <= pwdata[7:0] & (8'h01 << FSV_CFG_KEY_COMPARE_ACCESS_BIT);
          end else if (g != int'(FSV_OFS_OPTION[5:2]) && g != int'(FSV_OFS_STATUS[5:2])) begin
            hp_r[g] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  // security state: loaded at reset, opened by backdoor or blank check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_r <= FSV_SEC_RESET;
    end else if (load_pending_r) begin
      sec_r <= nonvolatile_option_byte[1:0];
    end else if (blank_check_done && flash_all_erased) begin
      sec_r <= FSV_SEC_OPEN;
    end else if (key_acc_clear && key_en && key_match) begin
      sec_r <= FSV_SEC_OPEN;
    end
  end

  fsv_key_cmp #(
    .KEY_BYTES(FSV_KEY_BYTES)
  ) u_key (
    .pclk(pclk),
    .presetn(presetn),
    .restart(load_pending_r || !key_acc),
    .cap(key_cap),
    .cap_ofs(cpu_req.addr[2:0]),
    .cap_data(cpu_req.wdata),
    .stored_key(backdoor_key_bytes),
    .match(key_match)
  );

  // debug path and mass erase qualification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bgnd_r <= 1'b0;
    end else if (load_pending_r) begin
      // pin level is taken on the first edge after reset release
      bgnd_r <= !background_mode_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_en_r <= 1'b0;
      mass_erase_r <= 1'b0;
      secure_r <= 1'b1;
    end else begin
      debug_en_r <= debug_enable_req && !is_secure && !load_pending_r;
      mass_erase_r <= mass_erase_req && !any_prot && !load_pending_r;
      secure_r <= is_secure;
    end
  end

  // apb read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (reg_idx == FSV_OFS_STATUS[5:2]) begin
      rd_word[7:0] = {3'h0, key_acc, redirect_on, any_prot, sec_r};
    end else if (reg_idx < 4'(FSV_HP_REGS)) begin
      rd_word[7:0] = hp_r[reg_idx];
    end
  end

  // zero wait state: data is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= (!pwrite && reg_hit) ? rd_word : 32'h0000_0000;
      pready_r <= 1'b1;
      pslverr_r <= !reg_hit;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_req = mem_r;
  assign cpu_rdata = cpu_rdata_r;
  assign mass_erase_go = mass_erase_r;
  assign debug_enable = debug_en_r;
  assign active_background = bgnd_r;
  assign secure = secure_r;

endmodule
